// File: src/reset_release_timer.sv
`timescale 1ns/100ps
module reset_release_timer (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_hold,
   input wire logic [reset_supervisor_pkg::CNT_W-1:0] i_limit,
   output logic o_expired
);

   // ****************************************
   // Quiet cycle counter
   // ****************************************
   logic [reset_supervisor_pkg::CNT_W-1:0] cnt_q;
   logic [reset_supervisor_pkg::CNT_W-1:0] cnt_d;
   logic done_q;
   logic done_d;

   always_comb begin
      cnt_d = cnt_q;
      done_d = done_q;
      if (i_hold) begin
         cnt_d = reset_supervisor_pkg::CNT_ZERO; // R16
         done_d = 1'b0;
      end else if (cnt_q < i_limit) begin
         cnt_d = cnt_q + reset_supervisor_pkg::CNT_ONE;
      end else begin
         done_d = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= reset_supervisor_pkg::CNT_ZERO;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   // Once released, a longer timeout written later does not reassert
   assign o_expired = !i_hold && (done_q || (cnt_q >= i_limit));

endmodule

// File: src/reset_supervisor_pkg.sv
package reset_supervisor_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_RESET_OUTPUT_CONFIG = 8'h19;
   localparam logic [7:0] ADDR_RESET_DEPENDENCY_LOW = 8'h1a;
   localparam logic [7:0] ADDR_RESET_DEPENDENCY_HIGH = 8'h1b;
   localparam logic [7:0] RESET_OUTPUT_CONFIG_RST = 8'h00;
   localparam logic [7:0] RESET_DEPENDENCY_RST = 8'h00;
   localparam logic [7:0] CONFIG_WRITE_MASK = 8'h7f;
   localparam logic [7:0] DEP_HIGH_WRITE_MASK = 8'h0f;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int COND_LSB = 0;
   localparam int POLARITY_BIT = 2;
   localparam int DRIVE_BIT = 3;
   localparam int TIMEOUT_LSB = 4;

   // ****************************************
   // Trigger classes
   // ****************************************
   localparam logic [1:0] COND_UNDER = 2'h0;
   localparam logic [1:0] COND_EARLY = 2'h1;
   localparam logic [1:0] COND_OVER = 2'h2;
   localparam logic [1:0] COND_EITHER = 2'h3;

   // ****************************************
   // Channels and timing
   // ****************************************
   localparam int NUM_CH = 12;
   localparam int LOW_CH = 8;
   localparam int CNT_W = 26;
   localparam int CLK_MHZ = 25;
   localparam int TO_US_0 = 25;
   localparam int TO_US_1 = 3000;
   localparam int TO_US_2 = 3750;
   localparam int TO_US_3 = 150000;
   localparam int TO_US_4 = 300000;
   localparam int TO_US_5 = 600000;
   localparam int TO_US_6 = 1200000;
   localparam int TO_US_7 = 2400000;
   localparam int TO_CYC_0 = TO_US_0 * CLK_MHZ;
   localparam int TO_CYC_1 = TO_US_1 * CLK_MHZ;
   localparam int TO_CYC_2 = TO_US_2 * CLK_MHZ;
   localparam int TO_CYC_3 = TO_US_3 * CLK_MHZ;
   localparam int TO_CYC_4 = TO_US_4 * CLK_MHZ;
   localparam int TO_CYC_5 = TO_US_5 * CLK_MHZ;
   localparam int TO_CYC_6 = TO_US_6 * CLK_MHZ;
   localparam int TO_CYC_7 = TO_US_7 * CLK_MHZ;
   localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 26'h1;

   // ****************************************
   // Fault log shutdown minimums
   // ****************************************
   localparam int SHUT_MS_FULL = 306;
   localparam int SHUT_MS_LINES = 90;
   localparam int SHUT_MS_ADC = 252;

endpackage

// File: src/supervisor_reset_output.sv
`timescale 1ns/100ps
// What this block does
// R1: Reset held through power-up and power-down; released after timeout post-sequence.
// R2: Power-up done when a final-slot input rises above undervoltage.
// R3: No final-slot inputs: power-up done when slot delay expires.
// R4: Inputs with any critical-fault enable also drive reset.
// R5: Condition field selects undervoltage, early warning, overvoltage or either.
// R6: Config bit 2 sets polarity: 0 active-low, 1 active-high.
// R7: Config bit 3 sets drive: 0 push-pull, 1 open-drain.
// R8: Timeout field bits 6:4 picks release delay, 25us to 2400ms.
// R9: Dependency bits pick inputs; high register only on twelve-channel part.
// R10: Manual reset mode: low on pin four asserts reset.
// R11: Host keeps supplies off 306, 90 or 252 ms after fault log.
// R12: Dependent mode: watchdog idle until sequencing done and reset released.
// R13: Independent mode: watchdog runs once supply good and boot finished.
// R14: Watchdog mode bit: 0 dependent, 1 independent.
// R15: Any over/undervoltage during power-up or power-down kills enables.
// R16: Trigger during timeout keeps reset and restarts full timeout.
module supervisor_reset_output #(
   parameter logic [181:0] TO_CYC_TAB = {
      26'(reset_supervisor_pkg::TO_CYC_7),
      26'(reset_supervisor_pkg::TO_CYC_6),
      26'(reset_supervisor_pkg::TO_CYC_5),
      26'(reset_supervisor_pkg::TO_CYC_4),
      26'(reset_supervisor_pkg::TO_CYC_3),
      26'(reset_supervisor_pkg::TO_CYC_2),
      26'(reset_supervisor_pkg::TO_CYC_1)}
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_twelve_ch,
   input wire logic i_supply_ok,
   input wire logic i_boot_done,
   input wire logic i_power_up_active,
   input wire logic i_power_down_active,
   input wire logic [11:0] i_slot12_assign,
   input wire logic [11:0] i_above_uv,
   input wire logic i_slot_delay_done,
   input wire logic [11:0] i_uv_fault,
   input wire logic [11:0] i_ew_fault,
   input wire logic [11:0] i_ov_fault,
   input wire logic [11:0] i_crit_en,
   input wire logic i_wd_indep_mode,
   input wire logic i_mr_enable,
   input wire logic i_general_io_four,
   output logic o_reset_out,
   output logic o_reset_oe,
   output logic o_reset_active,
   output logic o_power_up_done,
   output logic o_watchdog_active,
   output logic o_seq_enable_kill,
   output logic [7:0] o_reg_rdata
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [11:0] class_faults(input logic [1:0] cond,
         input logic [11:0] uv, input logic [11:0] ew,
         input logic [11:0] ov);
      logic [11:0] f;
      f = uv;
      unique case (cond)
         reset_supervisor_pkg::COND_UNDER: f = uv;
         reset_supervisor_pkg::COND_EARLY: f = ew;
         reset_supervisor_pkg::COND_OVER: f = ov;
         reset_supervisor_pkg::COND_EITHER: f = uv | ov;
      endcase
      return f;
   endfunction

   function automatic logic [25:0] timeout_cycles(input logic [2:0] code);
      logic [25:0] c;
      c = 26'(reset_supervisor_pkg::TO_CYC_0);
      unique case (code)
         3'h0: c = 26'(reset_supervisor_pkg::TO_CYC_0);
         3'h1: c = TO_CYC_TAB[25:0];
         3'h2: c = TO_CYC_TAB[51:26];
         3'h3: c = TO_CYC_TAB[77:52];
         3'h4: c = TO_CYC_TAB[103:78];
         3'h5: c = TO_CYC_TAB[129:104];
         3'h6: c = TO_CYC_TAB[155:130];
         3'h7: c = TO_CYC_TAB[181:156];
      endcase
      return c;
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] cfg_q, cfg_d, dep_lo_q, dep_lo_d, dep_hi_q, dep_hi_d;
   logic [7:0] rdata_d;

   always_comb begin
      cfg_d = cfg_q;
      dep_lo_d = dep_lo_q;
      dep_hi_d = dep_hi_q;
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            reset_supervisor_pkg::ADDR_RESET_OUTPUT_CONFIG:
               cfg_d = i_reg_wdata & reset_supervisor_pkg::CONFIG_WRITE_MASK;
            reset_supervisor_pkg::ADDR_RESET_DEPENDENCY_LOW:
               dep_lo_d = i_reg_wdata;
            reset_supervisor_pkg::ADDR_RESET_DEPENDENCY_HIGH:
               dep_hi_d = i_reg_wdata & reset_supervisor_pkg::DEP_HIGH_WRITE_MASK;
            default: ;
         endcase
      end
      unique case (i_reg_addr)
         reset_supervisor_pkg::ADDR_RESET_OUTPUT_CONFIG: rdata_d = cfg_q;
         reset_supervisor_pkg::ADDR_RESET_DEPENDENCY_LOW: rdata_d = dep_lo_q;
         reset_supervisor_pkg::ADDR_RESET_DEPENDENCY_HIGH: rdata_d = dep_hi_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_q <= reset_supervisor_pkg::RESET_OUTPUT_CONFIG_RST;
         dep_lo_q <= reset_supervisor_pkg::RESET_DEPENDENCY_RST;
         dep_hi_q <= reset_supervisor_pkg::RESET_DEPENDENCY_RST;
         o_reg_rdata <= 8'h00;
      end else begin
         cfg_q <= cfg_d;
         dep_lo_q <= dep_lo_d;
         dep_hi_q <= dep_hi_d;
         o_reg_rdata <= rdata_d;
      end
   end

   // ****************************************
   // Manual reset pin synchroniser
   // ****************************************
   logic mr_meta_q, mr_sync_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mr_meta_q <= 1'b1;
         mr_sync_q <= 1'b1;
      end else begin
         mr_meta_q <= i_general_io_four;
         mr_sync_q <= mr_meta_q;
      end
   end

   // ****************************************
   // Trigger and sequence status
   // ****************************************
   logic [11:0] dep_mask, sel_mask, faults;
   logic trig, mr_low, pu_complete, hold_req, expired;
   logic pu_done_q, pu_done_d;

   always_comb begin
      dep_mask = {dep_hi_q[3:0] & {4{i_twelve_ch}}, dep_lo_q}; // R9
      sel_mask = (dep_mask | i_crit_en) & {{4{i_twelve_ch}}, 8'hff}; // R4
      faults = class_faults(cfg_q[1:0], i_uv_fault, i_ew_fault,
         i_ov_fault); // R5
      trig = |(faults & sel_mask);
      mr_low = i_mr_enable && !mr_sync_q; // R10
      pu_complete = (|(i_slot12_assign & i_above_uv)) || // R2
         ((i_slot12_assign == 12'h000) && i_slot_delay_done); // R3
      pu_done_d = pu_done_q;
      if (i_power_down_active || !i_supply_ok) begin
         pu_done_d = 1'b0;
      end else if (i_power_up_active && pu_complete) begin
         pu_done_d = 1'b1;
      end
      hold_req = !pu_done_q || i_power_down_active || trig || mr_low; // R1
   end

   reset_release_timer u_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_hold(hold_req),
      .i_limit(timeout_cycles(cfg_q[6:4])), // R8
      .o_expired(expired)
   );

   // ****************************************
   // Outputs
   // ****************************************
   logic active_d, level_d, oe_d, wd_d, kill_d;

   always_comb begin
      active_d = !expired; // R16
      level_d = cfg_q[reset_supervisor_pkg::POLARITY_BIT] ? active_d
         : !active_d; // R6
      oe_d = 1'b1;
      if (cfg_q[reset_supervisor_pkg::DRIVE_BIT]) begin // R7
         oe_d = !level_d;
         level_d = 1'b0;
      end
      if (i_wd_indep_mode) begin // R14
         wd_d = i_supply_ok && i_boot_done; // R13
      end else begin
         wd_d = pu_done_d && !active_d; // R12
      end
      kill_d = (i_power_up_active || i_power_down_active) &&
         (|(i_uv_fault | i_ov_fault)); // R15
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pu_done_q <= 1'b0;
         o_reset_active <= 1'b1;
         o_reset_out <= 1'b0;
         o_reset_oe <= 1'b1;
         o_power_up_done <= 1'b0;
         o_watchdog_active <= 1'b0;
         o_seq_enable_kill <= 1'b0;
      end else begin
         pu_done_q <= pu_done_d;
         o_reset_active <= active_d;
         o_reset_out <= level_d;
         o_reset_oe <= oe_d;
         o_power_up_done <= pu_done_d;
         o_watchdog_active <= wd_d;
         o_seq_enable_kill <= kill_d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [25:0] quiet_run_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         quiet_run_q <= 26'h0;
      end else if (hold_req) begin
         quiet_run_q <= 26'h0;
      end else if (quiet_run_q != 26'h3ffffff) begin
         quiet_run_q <= quiet_run_q + 26'h1;
      end
   end

   property p_held_until_done;
      @(posedge i_sys_clk) disable iff (i_rst)
      (!pu_done_q || i_power_down_active) |=> o_reset_active;
   endproperty
   a_held_until_done: assert property (p_held_until_done) // R1
      else $error("reset released before power-up done");

   property p_slot_rise;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_power_up_active && !i_power_down_active && i_supply_ok &&
         |(i_slot12_assign & i_above_uv)) |=> pu_done_q;
   endproperty
   a_slot_rise: assert property (p_slot_rise) // R2
      else $error("final slot rise did not complete power-up");

   property p_slot_delay;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_power_up_active && !i_power_down_active && i_supply_ok &&
         i_slot12_assign == 12'h000 && i_slot_delay_done) |=> pu_done_q;
   endproperty
   a_slot_delay: assert property (p_slot_delay) // R3
      else $error("slot delay did not complete power-up");

   property p_crit_input;
      @(posedge i_sys_clk) disable iff (i_rst)
      (|(faults & i_crit_en & 12'h0ff)) |=> o_reset_active;
   endproperty
   a_crit_input: assert property (p_crit_input) // R4
      else $error("critical input fault did not assert reset");

   property p_cond_over;
      @(posedge i_sys_clk) disable iff (i_rst)
      (cfg_q[1:0] == 2'h2 && |(i_ov_fault & {4'h0, dep_lo_q})) |=>
         o_reset_active;
   endproperty
   a_cond_over: assert property (p_cond_over) // R5
      else $error("overvoltage class did not assert reset");

   property p_polarity;
      @(posedge i_sys_clk) disable iff (i_rst)
      (!cfg_q[3] && $stable(cfg_q)) |->
         (o_reset_out == (cfg_q[2] ? o_reset_active : !o_reset_active));
   endproperty
   a_polarity: assert property (p_polarity) // R6
      else $error("reset level does not match polarity");

   property p_open_drain;
      @(posedge i_sys_clk) disable iff (i_rst)
      (cfg_q[3] && $stable(cfg_q)) |-> (!o_reset_out &&
         o_reset_oe == (cfg_q[2] ? !o_reset_active : o_reset_active));
   endproperty
   a_open_drain: assert property (p_open_drain) // R7
      else $error("open-drain drive wrong");

   property p_timeout_length;
      @(posedge i_sys_clk) disable iff (i_rst)
      ($fell(o_reset_active) && $stable(cfg_q)) |->
         ($past(quiet_run_q) >= timeout_cycles(cfg_q[6:4]));
   endproperty
   a_timeout_length: assert property (p_timeout_length) // R8
      else $error("reset released before full timeout");

   property p_manual;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_mr_enable && !mr_sync_q) |=> o_reset_active;
   endproperty
   a_manual: assert property (p_manual) // R10
      else $error("manual reset did not assert reset");

   property p_wd_dependent;
      @(posedge i_sys_clk) disable iff (i_rst)
      ($past(i_wd_indep_mode) == 1'b0 && o_watchdog_active) |->
         (!o_reset_active && o_power_up_done);
   endproperty
   a_wd_dependent: assert property (p_wd_dependent) // R12
      else $error("dependent watchdog active too early");

   property p_wd_independent;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_wd_indep_mode && i_supply_ok && i_boot_done) |=> o_watchdog_active;
   endproperty
   a_wd_independent: assert property (p_wd_independent) // R13
      else $error("independent watchdog not active");

   property p_enable_kill;
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_power_up_active && |i_uv_fault) |=> o_seq_enable_kill;
   endproperty
   a_enable_kill: assert property (p_enable_kill) // R15
      else $error("sequence enables not killed on fault");

endmodule

// File: testbench/reset_receiver_model.sv
`timescale 1ns/100ps
module reset_receiver_model (
   input wire logic i_reset_out,
   input wire logic i_reset_oe,
   input wire logic i_active_high,
   output logic o_wire,
   output logic o_in_reset
);
   // ****************************************
   // Pin with pull-up, host view
   // ****************************************
   always_comb begin
      o_wire = i_reset_oe ? i_reset_out : 1'b1;
      o_in_reset = (o_wire == i_active_high);
   end

   // ****************************************
   // Host off time after a fault log
   // ****************************************
   function automatic int min_off_ms(input int save_code);
      case (save_code)
         0: return 306;
         1: return 90;
         2: return 252;
         default: return 0;
      endcase
   endfunction
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   int to_tab[8] = '{625, 40, 48, 56, 64, 72, 80, 88};
   logic clk, rst, wr, twelve, sok, boot, pua, pda, sdd, wdi, mre, gio4;
   logic [7:0] addr, wdata, rd;
   logic [11:0] slot, auv, uvf, ewf, ovf, crit;
   logic rout, roe, ract, pud, wda, kill, wire_l, host_rst;
   int failures, num_checks, seed, m_cfg, m_dlo, m_dhi, ch, d;
   logic e;

   supervisor_reset_output #(.TO_CYC_TAB({26'h58, 26'h50, 26'h48, 26'h40,
      26'h38, 26'h30, 26'h28}))
   i_supervisor_reset_output (.i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_twelve_ch(twelve),
      .i_supply_ok(sok), .i_boot_done(boot), .i_power_up_active(pua),
      .i_power_down_active(pda), .i_slot12_assign(slot), .i_above_uv(auv),
      .i_slot_delay_done(sdd), .i_uv_fault(uvf), .i_ew_fault(ewf),
      .i_ov_fault(ovf), .i_crit_en(crit), .i_wd_indep_mode(wdi),
      .i_mr_enable(mre), .i_general_io_four(gio4), .o_reset_out(rout),
      .o_reset_oe(roe), .o_reset_active(ract), .o_power_up_done(pud),
      .o_watchdog_active(wda), .o_seq_enable_kill(kill), .o_reg_rdata(rd));

   reset_receiver_model i_reset_receiver_model (.i_reset_out(rout),
      .i_reset_oe(roe), .i_active_high(m_cfg[2]), .o_wire(wire_l),
      .o_in_reset(host_rst));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      addr = a;
      wdata = v;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
      if (a == 8'h19) m_cfg = v & 8'h7f;
      if (a == 8'h1a) m_dlo = v;
      if (a == 8'h1b) m_dhi = v & 8'h0f;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
      addr = a;
      tick(2);
      check(rd, x);
   endtask
   function automatic logic exp_trig();
      logic [11:0] sel, f;
      sel = {m_dhi[3:0], m_dlo[7:0]} | crit;
      if (!twelve) sel[11:8] = 4'h0;
      case (m_cfg[1:0])
         0: f = uvf;
         1: f = ewf;
         2: f = ovf;
         default: f = uvf | ovf;
      endcase
      return |(sel & f);
   endfunction
   task automatic pin_chk(input logic act);
      logic lvl;
      lvl = m_cfg[2] ? act : !act;
      check(8'(ract), 8'(act));
      check(8'(host_rst), 8'(act));
      check(8'({roe, rout}), 8'(m_cfg[3] ? {!lvl, 1'b0} : {1'b1, lvl}));
   endtask
   task automatic wait_release(input int n);
      int c;
      c = 0;
      while (ract === 1'b1 && c < n + 10) begin
         tick(1);
         c++;
      end
      check(8'(c >= n && c <= n + 4), 8'h1);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog, sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #800000;
      failures++;
      end_of_test();
   end
   initial begin
      seed = 98;
      {rst, pua, sok, boot, gio4} = 5'h1f;
      {wr, twelve, pda, sdd, wdi, mre} = 6'h0;
      {addr, wdata, slot, auv, uvf, ewf, ovf, crit} = '0;
      {m_cfg, m_dlo, m_dhi} = '0;
      tick(8);
      rst = 1'b0;
      pin_chk(1'b1);
      rd_reg(8'h19, 8'h00);
      for (int a = 8'h19; a < 8'h1d; a++) begin
         d = $random(seed);
         wr_reg(8'(a), d[7:0]);
         rd_reg(8'(a), 8'(a == 8'h19 ? m_cfg : a == 8'h1a ? m_dlo :
            a == 8'h1b ? m_dhi : 0));
      end
      wr_reg(8'h19, 8'h10);
      wr_reg(8'h1a, 8'h00);
      wr_reg(8'h1b, 8'h00);
      uvf[0] = 1'b1;
      tick(2);
      check(8'(kill), 8'h1);
      uvf[0] = 1'b0;
      tick(60);
      pin_chk(1'b1);
      slot = 12'h001;
      auv = 12'h001;
      tick(1);
      pua = 1'b0;
      wait_release(40);
      check(8'({pud, wda}), 8'h3);
      for (int c = 0; c < 4; c++) begin
         for (int t = 0; t < 3; t++) begin
            ch = {$random(seed)} % 8;
            wr_reg(8'h19, 8'(c | 16));
            wr_reg(8'h1a, 8'(1 << ch));
            uvf[ch] = (t == 0);
            ewf[ch] = (t == 1);
            ovf[ch] = (t == 2);
            tick(3);
            e = exp_trig();
            pin_chk(e);
            {uvf, ewf, ovf} = '0;
            check(8'(kill), 8'h0);
            if (e) wait_release(40);
         end
      end
      wr_reg(8'h19, 8'h10);
      wr_reg(8'h1a, 8'h00);
      wr_reg(8'h1b, 8'h01);
      uvf[8] = 1'b1;
      tick(3);
      pin_chk(exp_trig());
      twelve = 1'b1;
      tick(3);
      pin_chk(exp_trig());
      uvf[8] = 1'b0;
      wait_release(40);
      wr_reg(8'h1b, 8'h00);
      wr_reg(8'h19, 8'h12);
      crit[5] = 1'b1;
      ovf[5] = 1'b1;
      tick(3);
      pin_chk(1'b1);
      ovf[5] = 1'b0;
      crit[5] = 1'b0;
      wait_release(40);
      wr_reg(8'h1a, 8'h01);
      for (int k = 0; k < 8; k++) begin
         wr_reg(8'h19, 8'((k << 4) | ((k & 3) << 2)));
         uvf[0] = 1'b1;
         tick(3);
         pin_chk(1'b1);
         uvf[0] = 1'b0;
         if (k == 3) begin
            tick(20);
            uvf[0] = 1'b1;
            tick(2);
            pin_chk(1'b1);
            uvf[0] = 1'b0;
         end
         wait_release(to_tab[k]);
         pin_chk(1'b0);
      end
      wr_reg(8'h19, 8'h10);
      mre = 1'b1;
      gio4 = 1'b0;
      tick(4);
      pin_chk(1'b1);
      check(8'(wda), 8'h0);
      wdi = 1'b1;
      tick(2);
      check(8'(wda), 8'h1);
      wdi = 1'b0;
      gio4 = 1'b1;
      wait_release(40);
      check(8'(wda), 8'h1);
      mre = 1'b0;
      gio4 = 1'b0;
      tick(4);
      pin_chk(1'b0);
      gio4 = 1'b1;
      pda = 1'b1;
      tick(3);
      pin_chk(1'b1);
      {pda, slot, auv} = '0;
      pua = 1'b1;
      tick(20);
      check(8'(pud), 8'h0);
      sdd = 1'b1;
      tick(1);
      pua = 1'b0;
      wait_release(40);
      sok = 1'b0;
      boot = 1'b0;
      wdi = 1'b1;
      tick(3);
      pin_chk(1'b1);
      check(8'({pud, wda}), 8'h0);
      sok = 1'b1;
      tick(2);
      check(8'(wda), 8'h0);
      boot = 1'b1;
      tick(2);
      check(8'(wda), 8'h1);
      end_of_test();
   end
endmodule
